// file: verilog/converter_sequencing_irq_bank.sv
// Summary of operation
// R1: Stop delay bits 7:4, n ms after fall
// R2: Start delay bits 3:0, n ms after rise
// R3: Soft reset restores defaults, reloads, resets serial
// R4: Soft reset bit clears itself
// R5: Bit 3 picks warning level 125 or 105
// R6: Config bit 2 drives second enable pulldown
// R7: Config bit 1 drives first enable pulldown
// R8: Config bit 0 turns spread spectrum on
// R9: Bits 7:4 summarise converter cause registers
// R10: Summary drops when cause register reads zero
// R11: Shutdown flag latches, stops and blocks converter
// R12: Warning flag latches at selected threshold
// R13: Reset flag latches on startup, undervoltage, soft
// R14: Load-ready flag latches on new measurement
// R15: Host writes one to clear flags 3:0
// R16: Converter cause registers feed the summaries
// R17: Live status shows raw thermal conditions
// R18: Millisecond tick counts delays, restarts on edges
// R19: Flag set beats simultaneous host clear
`timescale 1ns/1ps
`default_nettype none
`include "conv_bank_map.svh"

module converter_sequencing_irq_bank #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
  input  wire logic                    clock,
  input  wire logic                    chip_reset_input,
  input  wire logic                    enable_input,
  input  wire logic                    analog_supply_low,
  input  wire conv_bank_pkg::die_temp_s die_temp,
  input  wire conv_bank_pkg::reg_req_s  reg_req,
  input  wire logic [3:0][7:0]         converter_cause,
  input  wire logic                    load_result_ready,
  output logic [7:0]                   rd_data,
  output logic                         converter0_enable,
  output logic                         thermal_warning_threshold_select,
  output logic                         first_enable_pulldown,
  output logic                         second_enable_pulldown,
  output logic                         spread_spectrum_on,
  output logic                         otp_reload,
  output logic                         serial_reset
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic hit(
    input conv_bank_pkg::reg_byte_t addr,
    input conv_bank_pkg::reg_byte_t target
  );
    hit = (addr == target);
  endfunction

  wire wr_delay  = reg_req.wr && hit(reg_req.addr, `ADDR_ENABLE_DELAY);
  wire wr_reset  = reg_req.wr && hit(reg_req.addr, `ADDR_SOFT_RESET);
  wire wr_config = reg_req.wr && hit(reg_req.addr, `ADDR_DEVICE_CONFIG);
  wire wr_irq    = reg_req.wr && hit(reg_req.addr, `ADDR_TOP_IRQ_FLAGS);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int unsigned NUM_PINS = 5;

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;

  assign pin_raw = {enable_input, analog_supply_low,
                    die_temp.above_shutdown, die_temp.above_125c,
                    die_temp.above_105c};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!chip_reset_input) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire enable_s   = sync2_q[4];
  wire supply_low = sync2_q[3];
  wire above_sd   = sync2_q[2];
  wire above_125  = sync2_q[1];
  wire above_105  = sync2_q[0];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] delay_q;
  logic       soft_reset_q;
  logic [3:0] config_q;
  logic [3:0] irq_q;
  logic [3:0] irq_d;
  logic       startup_q;
  logic [7:0] rd_data_q;
  logic       otp_reload_q;
  logic       serial_reset_q;

  // Power-on start-up, undervoltage and soft reset share one path
  wire local_clear = soft_reset_q | supply_low | startup_q; // R13

  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      startup_q <= 1'b1;
    end else begin
      startup_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      delay_q <= `ENABLE_DELAY_RST;
    end else if (local_clear) begin // R3
      delay_q <= `ENABLE_DELAY_RST;
    end else if (wr_delay) begin
      delay_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      soft_reset_q <= `SOFT_RESET_RST;
    end else if (local_clear) begin // R4
      soft_reset_q <= `SOFT_RESET_RST;
    end else if (wr_reset) begin // R3
      soft_reset_q <= reg_req.wdata[`SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      config_q <= `DEVICE_CONFIG_RST;
    end else if (local_clear) begin // R3
      config_q <= `DEVICE_CONFIG_RST;
    end else if (wr_config) begin
      config_q <= reg_req.wdata[3:0];
    end
  end

  // Reload of one-time settings and serial logic reset
  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      otp_reload_q   <= 1'b0;
      serial_reset_q <= 1'b0;
    end else begin
      otp_reload_q   <= local_clear; // R3
      serial_reset_q <= soft_reset_q | supply_low; // R3
    end
  end

  assign thermal_warning_threshold_select =
    config_q[`CFG_WARN_SELECT_BIT]; // R5
  assign second_enable_pulldown = config_q[`CFG_SECOND_PD_BIT]; // R6
  assign first_enable_pulldown  = config_q[`CFG_FIRST_PD_BIT]; // R7
  assign spread_spectrum_on     = config_q[`CFG_SPREAD_BIT]; // R8
  assign otp_reload             = otp_reload_q;
  assign serial_reset           = serial_reset_q;

  // ------------------------------------------------------------
  // Thermal and interrupt flags
  // ------------------------------------------------------------
  wire warning_live = config_q[`CFG_WARN_SELECT_BIT] ? above_105
                                                     : above_125; // R5

  logic [3:0] irq_set;
  logic [3:0] irq_clear;
  logic [3:0] irq_keep;
  logic [3:0] summary;

  assign irq_set[`IRQ_SHUTDOWN_BIT]   = above_sd; // R11
  assign irq_set[`IRQ_WARNING_BIT]    = warning_live; // R12
  assign irq_set[`IRQ_RESET_BIT]      = local_clear; // R13
  assign irq_set[`IRQ_LOAD_READY_BIT] = load_result_ready; // R14

  assign irq_clear = wr_irq ? reg_req.wdata[3:0] : 4'h0; // R15
  assign irq_keep  = local_clear ? `TOP_IRQ_FLAGS_RST : irq_q;
  assign irq_d     = irq_set | (irq_keep & ~irq_clear); // R19

  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      irq_q <= `TOP_IRQ_FLAGS_RST;
    end else begin
      irq_q <= irq_d;
    end
  end

  generate
    for (gi = 0; gi < 4; gi++) begin : g_summary
      assign summary[gi] = |converter_cause[gi]; // R9 R10 R16
    end
  endgenerate

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  wire [7:0] irq_view  = {summary, irq_q};
  wire [7:0] live_view = {4'h0, above_sd, warning_live, 2'h0}; // R17
  wire [7:0] rd_mux =
    hit(reg_req.addr, `ADDR_ENABLE_DELAY)    ? delay_q :
    hit(reg_req.addr, `ADDR_SOFT_RESET)      ? {7'h00, soft_reset_q} :
    hit(reg_req.addr, `ADDR_DEVICE_CONFIG)   ? {4'h0, config_q} :
    hit(reg_req.addr, `ADDR_TOP_IRQ_FLAGS)   ? irq_view :
    hit(reg_req.addr, `ADDR_TOP_LIVE_STATUS) ? live_view : 8'h00;

  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      rd_data_q <= `READ_DATA_RST;
    end else if (reg_req.rd) begin
      rd_data_q <= rd_mux;
    end
  end

  assign rd_data = rd_data_q;

  // ------------------------------------------------------------
  // Enable sequencing
  // ------------------------------------------------------------
  logic enable_prev_q;
  logic target_q;
  logic conv_en_q;
  logic delay_done;

  wire enable_rise = enable_s & ~enable_prev_q;
  wire enable_fall = ~enable_s & enable_prev_q;
  wire [3:0] delay_code =
    enable_rise ? delay_q[`START_DELAY_MSB:`START_DELAY_LSB] // R2
                : delay_q[`STOP_DELAY_MSB:`STOP_DELAY_LSB]; // R1

  // Clearing the edge history makes a held enable restart the converter
  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      enable_prev_q <= 1'b0;
      target_q      <= 1'b0;
    end else if (local_clear) begin // R13
      enable_prev_q <= 1'b0;
      target_q      <= 1'b0;
    end else begin
      enable_prev_q <= enable_s;
      target_q      <= enable_rise ? 1'b1 :
                       enable_fall ? 1'b0 : target_q;
    end
  end

  ms_delay_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_delay_timer (
    .clock   (clock),
    .chip_reset_input    (chip_reset_input),
    .load    (enable_rise | enable_fall), // R18
    .code    (delay_code),
    .expired (delay_done)
  );

  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      conv_en_q <= 1'b0;
    end else if (local_clear || irq_q[`IRQ_SHUTDOWN_BIT]) begin // R11
      conv_en_q <= 1'b0;
    end else if (delay_done) begin // R1 R2
      conv_en_q <= target_q;
    end
  end

  assign converter0_enable = conv_en_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_soft_reset_self_clear;
    @(posedge clock) disable iff (!chip_reset_input)
    soft_reset_q |=> !soft_reset_q;
  endproperty
  a_soft_reset_self_clear: assert property (p_soft_reset_self_clear) // R4
    else $error("soft reset bit did not clear itself");

  property p_soft_reset_flags;
    @(posedge clock) disable iff (!chip_reset_input)
    soft_reset_q |=> irq_q[`IRQ_RESET_BIT] && otp_reload_q;
  endproperty
  a_soft_reset_flags: assert property (p_soft_reset_flags) // R13
    else $error("soft reset did not latch reset flag");

  property p_config_default;
    @(posedge clock) disable iff (!chip_reset_input)
    soft_reset_q |=> (config_q == `DEVICE_CONFIG_RST) &&
                     (delay_q == `ENABLE_DELAY_RST) && serial_reset_q;
  endproperty
  a_config_default: assert property (p_config_default) // R3
    else $error("soft reset did not restore defaults");

  property p_shutdown_blocks;
    @(posedge clock) disable iff (!chip_reset_input)
    irq_q[`IRQ_SHUTDOWN_BIT] |=> !conv_en_q;
  endproperty
  a_shutdown_blocks: assert property (p_shutdown_blocks) // R11
    else $error("converter enabled while shutdown flag set");

  property p_set_beats_clear;
    @(posedge clock) disable iff (!chip_reset_input)
    load_result_ready && wr_irq &&
      reg_req.wdata[`IRQ_LOAD_READY_BIT] |=> irq_q[`IRQ_LOAD_READY_BIT];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) // R19
    else $error("load-ready event lost to host clear");

  property p_write_one_clears;
    @(posedge clock) disable iff (!chip_reset_input)
    wr_irq && reg_req.wdata[`IRQ_LOAD_READY_BIT] && !load_result_ready
      |=> !irq_q[`IRQ_LOAD_READY_BIT];
  endproperty
  a_write_one_clears: assert property (p_write_one_clears) // R15
    else $error("write one did not clear load-ready flag");

  property p_write_zero_keeps;
    @(posedge clock) disable iff (!chip_reset_input)
    wr_irq && irq_q[`IRQ_WARNING_BIT] && !local_clear &&
      !reg_req.wdata[`IRQ_WARNING_BIT] |=> irq_q[`IRQ_WARNING_BIT];
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps) // R15
    else $error("write zero disturbed warning flag");

  property p_summary_read;
    @(posedge clock) disable iff (!chip_reset_input)
    reg_req.rd && hit(reg_req.addr, `ADDR_TOP_IRQ_FLAGS) |=>
      rd_data_q[`IRQ_SUMMARY_MSB:`IRQ_SUMMARY_LSB] == $past(summary);
  endproperty
  a_summary_read: assert property (p_summary_read) // R9
    else $error("summary bits do not match cause registers");

  property p_zero_start_delay;
    @(posedge clock) disable iff (!chip_reset_input)
    enable_rise && !local_clear && (delay_q[3:0] == 4'h0) ##1
      !local_clear && !irq_q[`IRQ_SHUTDOWN_BIT] |=> conv_en_q;
  endproperty
  a_zero_start_delay: assert property (p_zero_start_delay) // R2
    else $error("zero start delay did not enable converter");

endmodule // converter_sequencing_irq_bank

`default_nettype wire

// file: verilog/conv_bank_map.svh
`ifndef CONV_BANK_MAP_SVH
`define CONV_BANK_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ADDR_ENABLE_DELAY     8'h12
`define ADDR_SOFT_RESET       8'h16
`define ADDR_DEVICE_CONFIG    8'h17
`define ADDR_TOP_IRQ_FLAGS    8'h18
`define ADDR_TOP_LIVE_STATUS  8'h1B

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ENABLE_DELAY_RST      8'h00
`define SOFT_RESET_RST        1'h0
`define DEVICE_CONFIG_RST     4'h6
`define TOP_IRQ_FLAGS_RST     4'h0
`define READ_DATA_RST         8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define STOP_DELAY_MSB        7
`define STOP_DELAY_LSB        4
`define START_DELAY_MSB       3
`define START_DELAY_LSB       0
`define SOFT_RESET_BIT        0
`define CFG_WARN_SELECT_BIT   3
`define CFG_SECOND_PD_BIT     2
`define CFG_FIRST_PD_BIT      1
`define CFG_SPREAD_BIT        0
`define IRQ_SUMMARY_MSB       7
`define IRQ_SUMMARY_LSB       4
`define IRQ_SHUTDOWN_BIT      3
`define IRQ_WARNING_BIT       2
`define IRQ_RESET_BIT         1
`define IRQ_LOAD_READY_BIT    0
`define LIVE_SHUTDOWN_BIT     3
`define LIVE_WARNING_BIT      2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLOCK_PERIOD_PS       5000
`define ONE_MS_PS             1000000000
`define MS_CYCLES             (`ONE_MS_PS / `CLOCK_PERIOD_PS)
`define MS_COUNT_W            18
`define DELAY_CODE_W          4

`endif

// file: verilog/conv_bank_pkg.sv
`default_nettype none

package conv_bank_pkg;

  typedef logic [7:0] reg_byte_t;

  // Register access from the serial interface logic
  typedef struct packed {
    reg_byte_t addr;
    logic      wr;
    logic      rd;
    reg_byte_t wdata;
  } reg_req_s;

  // Die temperature comparator pins
  typedef struct packed {
    logic above_shutdown;
    logic above_125c;
    logic above_105c;
  } die_temp_s;

  typedef enum logic [0:0] {
    TMR_IDLE = 1'b0,
    TMR_RUN  = 1'b1
  } timer_state_e;

endpackage

`default_nettype wire

// file: verilog/ms_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "conv_bank_map.svh"

module ms_delay_timer #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     chip_reset_input,
  input  wire logic                     load,
  input  wire logic [`DELAY_CODE_W-1:0] code,
  output logic                          expired
);

  localparam logic [`MS_COUNT_W-1:0] LAST_CYCLE =
    `MS_COUNT_W'(MS_CYCLES - 1);
  localparam logic [`DELAY_CODE_W-1:0] ONE_MS = `DELAY_CODE_W'(1);

  conv_bank_pkg::timer_state_e state_q;
  logic [`MS_COUNT_W-1:0]      cycle_q;
  logic [`DELAY_CODE_W-1:0]    ms_left_q;
  logic                        expired_q;

  wire tick      = (state_q == conv_bank_pkg::TMR_RUN) &&
                   (cycle_q == LAST_CYCLE);
  wire last_tick = tick && (ms_left_q == ONE_MS);

  // ------------------------------------------------------------
  // Millisecond tick and countdown, restarted by each load
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!chip_reset_input) begin
      state_q   <= conv_bank_pkg::TMR_IDLE;
      cycle_q   <= '0;
      ms_left_q <= '0;
      expired_q <= 1'b0;
    end else if (load) begin // R18
      cycle_q   <= '0;
      ms_left_q <= code;
      expired_q <= (code == '0);
      state_q   <= (code == '0) ? conv_bank_pkg::TMR_IDLE
                                : conv_bank_pkg::TMR_RUN;
    end else begin
      unique case (state_q)
        conv_bank_pkg::TMR_IDLE: begin
          expired_q <= 1'b0;
        end
        conv_bank_pkg::TMR_RUN: begin
          cycle_q   <= tick ? '0 : cycle_q + `MS_COUNT_W'(1);
          ms_left_q <= tick ? ms_left_q - ONE_MS : ms_left_q;
          expired_q <= last_tick;
          state_q   <= last_tick ? conv_bank_pkg::TMR_IDLE
                                 : conv_bank_pkg::TMR_RUN;
        end
      endcase
    end
  end

  assign expired = expired_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_zero_code_now;
    @(posedge clock) disable iff (!chip_reset_input)
    load && (code == '0) |=> expired;
  endproperty
  a_zero_code_now: assert property (p_zero_code_now) // R18
    else $error("zero delay code did not expire at once");

  property p_no_early_expiry;
    @(posedge clock) disable iff (!chip_reset_input)
    load && (code != '0) ##1 !load [*2] |-> !expired;
  endproperty
  a_no_early_expiry: assert property (p_no_early_expiry) // R18
    else $error("delay expired before one millisecond");

endmodule // ms_delay_timer

`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host side of the register port
// ------------------------------------------------------------
module host_model (
  input  wire logic                     clock,
  output var  conv_bank_pkg::reg_req_s  reg_req
);
  initial reg_req = '0;

  // One single-byte request, launched just after an edge
  task automatic access(input logic       wr,
                        input logic [7:0] addr,
                        input logic [7:0] data);
    @(posedge clock);
    #1;
    reg_req.addr  = addr;
    reg_req.wdata = data;
    reg_req.wr    = wr;
    reg_req.rd    = ~wr;
    @(posedge clock);
    #1;
    reg_req.wr    = 1'b0;
    reg_req.rd    = 1'b0;
    // Idle bus shows the inverse of the last value
    reg_req.addr  = ~addr;
    reg_req.wdata = ~data;
  endtask
endmodule  // host_model

`default_nettype wire

// file: test/converter_sequencing_irq_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module converter_sequencing_irq_bank_tb_top;
  localparam int unsigned MS = 10;
  logic                     clock;
  logic                     chip_reset_input;
  logic                     enable_input;
  logic                     analog_supply_low;
  conv_bank_pkg::die_temp_s die_temp;
  conv_bank_pkg::reg_req_s  reg_req;
  logic [3:0][7:0]          converter_cause;
  logic                     load_result_ready;
  logic [7:0]               rd_data;
  logic                     converter0_enable;
  logic                     warn_sel;
  logic                     pd1;
  logic                     pd2;
  logic                     spread;
  logic                     otp_reload;
  logic                     serial_reset;
  wire  [7:0]               cfg_pins = {4'h0, warn_sel, pd2, pd1, spread};
  int                       error_cnt = 0;
  int                       n_compared = 0;
  integer                   seed = 19896;
  logic [7:0]               exp_q[$];
  string                    name_q[$];
  logic                     rd_seen = 1'b0;

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  host_model host (.clock(clock), .reg_req(reg_req));

  converter_sequencing_irq_bank #(.MS_CYCLES(MS)) uut (
    .clock                            (clock),
    .chip_reset_input                             (chip_reset_input),
    .enable_input                     (enable_input),
    .analog_supply_low                (analog_supply_low),
    .die_temp                         (die_temp),
    .reg_req                          (reg_req),
    .converter_cause                  (converter_cause),
    .load_result_ready                (load_result_ready),
    .rd_data                          (rd_data),
    .converter0_enable                (converter0_enable),
    .thermal_warning_threshold_select (warn_sel),
    .first_enable_pulldown            (pd1),
    .second_enable_pulldown           (pd2),
    .spread_spectrum_on               (spread),
    .otp_reload                       (otp_reload),
    .serial_reset                     (serial_reset)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string name);
    exp_q.push_back(e);
    name_q.push_back(name);
    host.access(1'b0, a, 8'h00);
  endtask

  task automatic delay_chk(input logic lvl, input int code);
    int n;
    n = 0;
    enable_input = lvl;
    while (converter0_enable !== lvl && n < 400) begin
      tick(1);
      n++;
    end
    chk("enable delay window", 8'h01,
        8'((n >= code * MS + 2) && (n <= code * MS + 7)));
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Read data monitor
  // ------------------------------------------------------------
  always @(posedge clock) rd_seen <= reg_req.rd;

  always @(negedge clock) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      chk(name_q.pop_front(), exp_q.pop_front(), rd_data);
    end
  end

  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int         n;
    chip_reset_input = 1'b0;
    enable_input = 1'b0;
    analog_supply_low = 1'b0;
    die_temp = '0;
    converter_cause = '0;
    load_result_ready = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chip_reset_input = 1'b1;
    tick(3);
    chk("config pins", 8'h06, cfg_pins);
    rd(8'h12, 8'h00, "delay reg");
    rd(8'h16, 8'h00, "soft reset reg");
    rd(8'h17, 8'h06, "config reg");
    rd(8'h18, 8'h02, "startup flag");
    rd(8'h1B, 8'h00, "live status");
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h00, "unmapped");
    wr(8'h18, 8'h02);
    rd(8'h18, 8'h00, "reset flag cleared");
    for (int i = 0; i < 6; i++) begin
      v = (i < 4) ? (8'h01 << i) : 8'($random(seed));
      wr(8'h17, v);
      rd(8'h17, {4'h0, v[3:0]}, "config readback");
      tick(1);
      chk("config pins", {4'h0, v[3:0]}, cfg_pins);
    end
    wr(8'h17, 8'h0E);
    die_temp.above_105c = 1'b1;
    tick(4);
    rd(8'h1B, 8'h04, "live warning 105");
    rd(8'h18, 8'h04, "warning flag");
    wr(8'h17, 8'h06);
    tick(4);
    wr(8'h18, 8'h04);
    rd(8'h18, 8'h00, "no warning at 125");
    rd(8'h1B, 8'h00, "live below 125");
    die_temp = '0;
    load_result_ready = 1'b1;
    tick(1);
    load_result_ready = 1'b0;
    rd(8'h18, 8'h01, "load ready");
    wr(8'h18, 8'h00);
    rd(8'h18, 8'h01, "write zero keeps");
    fork
      wr(8'h18, 8'h01);
      begin
        tick(1);
        load_result_ready = 1'b1;
        tick(1);
        load_result_ready = 1'b0;
      end
    join
    rd(8'h18, 8'h01, "set beats clear");
    wr(8'h18, 8'h01);
    rd(8'h18, 8'h00, "load ready cleared");
    for (int i = 0; i < 4; i++) begin
      converter_cause[i] = 8'h80 >> i;
      tick(2);
      rd(8'h18, 8'h10 << i, "summary set");
      converter_cause[i] = 8'h00;
      tick(2);
      rd(8'h18, 8'h00, "summary drops");
    end
    wr(8'h12, 8'hF3);
    delay_chk(1'b1, 3);
    delay_chk(1'b0, 15);
    wr(8'h12, 8'h50);
    delay_chk(1'b1, 0);
    enable_input = 1'b0;
    tick(20);
    enable_input = 1'b1;
    tick(60);
    chk("pending stop dropped", 8'h01, 8'(converter0_enable));
    die_temp.above_shutdown = 1'b1;
    tick(6);
    chk("shutdown stops", 8'h00, 8'(converter0_enable));
    rd(8'h1B, 8'h08, "live shutdown");
    wr(8'h18, 8'h08);
    rd(8'h18, 8'h08, "clear while hot");
    die_temp = '0;
    enable_input = 1'b0;
    tick(10);
    enable_input = 1'b1;
    tick(20);
    chk("enable blocked", 8'h00, 8'(converter0_enable));
    wr(8'h18, 8'h08);
    rd(8'h18, 8'h00, "shutdown cleared");
    enable_input = 1'b0;
    tick(4);
    enable_input = 1'b1;
    tick(8);
    chk("enable after clear", 8'h01, 8'(converter0_enable));
    wr(8'h17, 8'h09);
    wr(8'h16, 8'h01);
    n = 0;
    while (otp_reload !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk("otp reload", 8'h01, 8'(otp_reload));
    chk("serial reset", 8'h01, 8'(serial_reset));
    chk("converter off", 8'h00, 8'(converter0_enable));
    rd(8'h16, 8'h00, "soft reset clears");
    rd(8'h17, 8'h06, "config default");
    rd(8'h18, 8'h02, "reset flag soft");
    wr(8'h18, 8'h02);
    rd(8'h18, 8'h00, "reset flag cleared again");
    analog_supply_low = 1'b1;
    tick(4);
    chk("serial reset supply", 8'h01, 8'(serial_reset));
    chk("converter off supply", 8'h00, 8'(converter0_enable));
    analog_supply_low = 1'b0;
    tick(4);
    rd(8'h18, 8'h02, "reset flag supply");
    tick(2);
    end_of_test();
  end
endmodule  // converter_sequencing_irq_bank_tb_top

`default_nettype wire
